// ==== logic/mdvu_pkg.sv ====
package mdvu_pkg;

  // ==========================================================================
  // widths and reset values
  localparam int WORD_W       = 32;
  localparam int HALF_W       = 16;
  localparam int REG_IDX_W    = 5;
  localparam int REGS_PER_SET = 32;
  localparam int REG_SETS     = 2;
  localparam int DIV_CNT_W    = 6;
  localparam int DIV_CLASSES  = 4;

  localparam logic [WORD_W-1:0] RESULT_RESET = 32'h0000_0000;

  typedef logic [DIV_CNT_W-1:0] mdvu_cnt_t;

  // ==========================================================================
  // divide timing per dividend class: 8, 16, 24, 32 significant bits
  localparam mdvu_cnt_t DIV_LATENCY [DIV_CLASSES] = '{6'h0C, 6'h13, 6'h1A, 6'h21};
  localparam mdvu_cnt_t DIV_SKIP    [DIV_CLASSES] = '{6'h17, 6'h0F, 6'h07, 6'h00};
  localparam mdvu_cnt_t DIV_ITER_FULL = 6'h20;
  localparam mdvu_cnt_t DIV_CNT_IDLE  = 6'h00;
  localparam mdvu_cnt_t DIV_CNT_LAST  = 6'h01;
  localparam mdvu_cnt_t DIV_CNT_STALL = 6'h03;

  // ==========================================================================
  // operations and sequencer states
  typedef enum logic [3:0] {
    OP_NONE                         = 4'h0,
    OP_SIGNED_MULTIPLY              = 4'h1,
    OP_UNSIGNED_MULTIPLY            = 4'h2,
    OP_MULTIPLY_ACCUMULATE          = 4'h3,
    OP_UNSIGNED_MULTIPLY_ACCUMULATE = 4'h4,
    OP_MULTIPLY_SUBTRACT            = 4'h5,
    OP_UNSIGNED_MULTIPLY_SUBTRACT   = 4'h6,
    OP_MULTIPLY_TO_REGISTER         = 4'h7,
    OP_SIGNED_DIVIDE                = 4'h8,
    OP_UNSIGNED_DIVIDE              = 4'h9,
    OP_MOVE_FROM_RESULT_HIGH        = 4'hA,
    OP_MOVE_FROM_RESULT_LOW         = 4'hB
  } mdvu_op_t;

  typedef enum logic [2:0] {
    SEQ_EMPTY  = 3'b001,
    SEQ_FIRST  = 3'b010,
    SEQ_SECOND = 3'b100
  } mdvu_seq_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic                 valid;
    mdvu_op_t             op;
    logic                 shadowSet;
    logic [REG_IDX_W-1:0] firstIdx;
    logic [REG_IDX_W-1:0] secondIdx;
    logic [REG_IDX_W-1:0] destIdx;
  } mdvu_issue_t;

  typedef struct packed {
    logic                 valid;
    logic                 shadowSet;
    logic [REG_IDX_W-1:0] idx;
    logic [WORD_W-1:0]    data;
  } mdvu_gpr_wr_t;

endpackage

// ==== logic/mdvu_regfile.sv ====
`timescale 1ns/10ps
module mdvu_regfile #(
  parameter int DEPTH = mdvu_pkg::REGS_PER_SET,
  parameter int SETS  = mdvu_pkg::REG_SETS
) (
  input  wire logic                                     core_clk,
  input  wire logic                                     clkEn,
  input  wire mdvu_pkg::mdvu_gpr_wr_t                   wr,
  input  wire logic [1:0]                               rdSet,
  input  wire logic [1:0][mdvu_pkg::REG_IDX_W-1:0]      rdIdx,
  output logic      [1:0][mdvu_pkg::WORD_W-1:0]         rdData
);
  import mdvu_pkg::*;

  logic [WORD_W-1:0] mem [SETS][DEPTH];

  // ==========================================================================
  // single write port, index zero stays zero
  always_ff @(posedge core_clk) begin
    if (clkEn && wr.valid && wr.idx != '0) begin
      mem[wr.shadowSet][wr.idx] <= wr.data;
    end
  end

  // ==========================================================================
  // two read ports with bypass from the write port
  for (genvar p = 0; p < 2; p++) begin : g_read
    always_comb begin
      if (rdIdx[p] == '0) begin
        rdData[p] = '0;
      end else if (clkEn && wr.valid && wr.shadowSet == rdSet[p] && wr.idx == rdIdx[p]) begin
        rdData[p] = wr.data;
      end else begin
        rdData[p] = mem[rdSet[p]][rdIdx[p]];
      end
    end
  end

endmodule // mdvu_regfile

// ==== logic/mdvu_mul_pass.sv ====
`timescale 1ns/10ps
module mdvu_mul_pass #(
  parameter int A_W = mdvu_pkg::WORD_W,
  parameter int B_W = mdvu_pkg::HALF_W
) (
  input  wire logic [A_W-1:0]         multiplicand,
  input  wire logic                   aSigned,
  input  wire logic [B_W-1:0]         multiplier,
  input  wire logic                   bSigned,
  output logic signed [A_W+B_W+1:0]   product
);

  // ==========================================================================
  // one pass of the wide-by-half array, sign chosen per operand
  assign product = $signed({aSigned & multiplicand[A_W-1], multiplicand})
                 * $signed({bSigned & multiplier[B_W-1], multiplier});

endmodule // mdvu_mul_pass

// ==== logic/mdvu_core.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] own pipeline, never halted by integer stalls
// [RULE2] 32x16 array; second operand picks pass count
// [RULE3] narrow multiply each clock, wide alternate clocks
// [RULE4] divide yields one quotient bit per clock
// [RULE5] skip 23/15/7 iterations by dividend width
// [RULE6] divide in flight stalls further unit issue
// [RULE7] high/low multiply latency/repeat 1/1 or 2/2
// [RULE8] register multiply latency/repeat 2/1 or 3/2
// [RULE9] divide latency/repeat 12/11 up to 33/32
// [RULE10] results land in high/low; moves copy out
// [RULE11] register multiply writes low product word
// [RULE12] accumulate adds, subtract removes, into high/low
// [RULE13] two register sets, two reads, bypassed write
// [RULE14] product upper high; remainder high, quotient low
module mdvu_core (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clkEn,
  input  wire mdvu_pkg::mdvu_issue_t         issue,
  input  wire mdvu_pkg::mdvu_gpr_wr_t        extWr,
  output logic                               stall,
  output logic [mdvu_pkg::WORD_W-1:0]        resultHigh,
  output logic [mdvu_pkg::WORD_W-1:0]        resultLow,
  output mdvu_pkg::mdvu_gpr_wr_t             gprWr
);
  import mdvu_pkg::*;

  // ==========================================================================
  // operation classes
  function automatic logic isMulFamily(input mdvu_op_t op);
    return op inside {OP_SIGNED_MULTIPLY, OP_UNSIGNED_MULTIPLY, OP_MULTIPLY_ACCUMULATE,
                      OP_UNSIGNED_MULTIPLY_ACCUMULATE, OP_MULTIPLY_SUBTRACT,
                      OP_UNSIGNED_MULTIPLY_SUBTRACT, OP_MULTIPLY_TO_REGISTER};
  endfunction

  function automatic logic isSignedOp(input mdvu_op_t op);
    return op inside {OP_SIGNED_MULTIPLY, OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_SUBTRACT,
                      OP_MULTIPLY_TO_REGISTER, OP_SIGNED_DIVIDE};
  endfunction

  function automatic logic isDivide(input mdvu_op_t op);
    return op inside {OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE};
  endfunction

  // value representable in the given number of bits
  function automatic logic sigFits(input logic [WORD_W-1:0] v, input logic sgn, input int bits);
    logic [WORD_W-1:0] top;
    top = sgn ? WORD_W'($signed(v) >>> (bits - 1)) : (v >> bits);
    return (top == 32'h0000_0000) || (sgn && top == 32'hFFFF_FFFF);
  endfunction

  // one restoring step: shift in next dividend bit, subtract if it fits
  function automatic logic [2*WORD_W-1:0] divStep(input logic [WORD_W-1:0] rem,
                                                  input logic [WORD_W-1:0] quo,
                                                  input logic [WORD_W-1:0] den);
    logic [WORD_W:0] shifted;
    logic            fits;
    shifted = {rem, quo[WORD_W-1]};
    fits    = shifted >= {1'b0, den};
    if (fits) begin
      return {WORD_W'(shifted - {1'b0, den}), quo[WORD_W-2:0], 1'b1};
    end
    return {shifted[WORD_W-1:0], quo[WORD_W-2:0], 1'b0};
  endfunction

  // ==========================================================================
  // operand fetch
  logic [1:0][WORD_W-1:0] rdData;
  logic [WORD_W-1:0]      opFirst;
  logic [WORD_W-1:0]      opSecond;
  mdvu_gpr_wr_t           portWr;
  logic                   accept;
  logic                   issueWide;

  // [RULE13] unit writeback owns the port
  assign portWr = gprWr.valid ? gprWr : extWr;

  mdvu_regfile #(
    .DEPTH (REGS_PER_SET),
    .SETS  (REG_SETS)
  ) u_regfile (
    .core_clk (core_clk),
    .clkEn    (clkEn),
    .wr       (portWr),
    .rdSet    ({2{issue.shadowSet}}),
    .rdIdx    ({issue.secondIdx, issue.firstIdx}),
    .rdData   (rdData)
  );

  assign opFirst  = rdData[0];
  assign opSecond = rdData[1];
  assign accept   = issue.valid && issue.op != OP_NONE && !stall;

  // [RULE2] pass count from second operand only
  assign issueWide = isMulFamily(issue.op)
                   && !sigFits(opSecond, isSignedOp(issue.op), HALF_W);

  // ==========================================================================
  // stage registers and sequencer
  mdvu_seq_t            seq;
  mdvu_seq_t            next_seq;
  mdvu_op_t             stOp;
  logic                 stSet;
  logic [REG_IDX_W-1:0] stDest;
  logic [WORD_W-1:0]    stA;
  logic [WORD_W-1:0]    stB;
  logic                 stWide;
  logic [2*WORD_W-1:0]  partial;

  // [RULE1] advances on clkEn alone, no integer stall input
  always_comb begin
    unique case (seq)
      SEQ_EMPTY:  next_seq = accept ? SEQ_FIRST : SEQ_EMPTY;
      SEQ_FIRST:  next_seq = stWide ? SEQ_SECOND : (accept ? SEQ_FIRST : SEQ_EMPTY);
      SEQ_SECOND: next_seq = accept ? SEQ_FIRST : SEQ_EMPTY;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq <= SEQ_EMPTY;
    end else if (clkEn) begin
      seq <= next_seq;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stOp   <= OP_NONE;
      stSet  <= 1'b0;
      stDest <= '0;
      stA    <= '0;
      stB    <= '0;
      stWide <= 1'b0;
    end else if (clkEn && accept) begin
      stOp   <= issue.op;
      stSet  <= issue.shadowSet;
      stDest <= issue.destIdx;
      stA    <= opFirst;
      stB    <= opSecond;
      stWide <= issueWide;
    end
  end

  // ==========================================================================
  // multiplier passes
  logic                      secondPass;
  logic                      stSigned;
  logic signed [WORD_W+HALF_W+1:0] passProduct;
  logic [2*WORD_W-1:0]       passExt;
  logic [2*WORD_W-1:0]       product;

  assign secondPass = seq == SEQ_SECOND;
  assign stSigned   = isSignedOp(stOp);

  // [RULE2] first operand full width, second taken a half at a time
  mdvu_mul_pass #(
    .A_W (WORD_W),
    .B_W (HALF_W)
  ) u_mul_pass (
    .multiplicand (stA),
    .aSigned      (stSigned),
    .multiplier   (secondPass ? stB[WORD_W-1:HALF_W] : stB[HALF_W-1:0]),
    .bSigned      (stSigned && (secondPass || !stWide)),
    .product      (passProduct)
  );

  assign passExt = (2*WORD_W)'(passProduct);
  assign product = secondPass ? partial + {passExt[2*WORD_W-HALF_W-1:0], 16'h0000} : passExt;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      partial <= '0;
    end else if (clkEn && seq == SEQ_FIRST && stWide) begin
      partial <= passExt;
    end
  end

  // ==========================================================================
  // divider
  mdvu_cnt_t         divCnt;
  mdvu_cnt_t         next_divCnt;
  mdvu_cnt_t         divIterTop;
  logic [WORD_W-1:0] divRem;
  logic [WORD_W-1:0] divQuo;
  logic [WORD_W-1:0] divDen;
  logic              divNegQ;
  logic              divNegR;
  logic              divStart;
  logic              divFinishing;
  logic [1:0]        divClass;
  logic [WORD_W-1:0] magA;
  logic [WORD_W-1:0] magB;
  logic [WORD_W-1:0] divHiFix;
  logic [WORD_W-1:0] divLoFix;

  assign divStart     = seq == SEQ_FIRST && isDivide(stOp);
  assign divFinishing = divCnt == DIV_CNT_LAST;
  assign magA = (stSigned && stA[WORD_W-1]) ? WORD_W'(-stA) : stA;
  assign magB = (stSigned && stB[WORD_W-1]) ? WORD_W'(-stB) : stB;

  // [RULE5] early-in on sign extension of the dividend
  always_comb begin
    if (sigFits(stA, stSigned, 8)) begin
      divClass = 2'h0;
    end else if (sigFits(stA, stSigned, 16)) begin
      divClass = 2'h1;
    end else if (sigFits(stA, stSigned, 24)) begin
      divClass = 2'h2;
    end else begin
      divClass = 2'h3;
    end
  end

  // [RULE9] counter spans the class latency
  always_comb begin
    if (divStart) begin
      next_divCnt = DIV_LATENCY[divClass] - DIV_CNT_LAST;
    end else if (divCnt != DIV_CNT_IDLE) begin
      next_divCnt = divCnt - DIV_CNT_LAST;
    end else begin
      next_divCnt = DIV_CNT_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt <= DIV_CNT_IDLE;
    end else if (clkEn) begin
      divCnt <= next_divCnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divIterTop <= DIV_CNT_IDLE;
      divRem     <= '0;
      divQuo     <= '0;
      divDen     <= '0;
      divNegQ    <= 1'b0;
      divNegR    <= 1'b0;
    end else if (clkEn) begin
      if (divStart) begin
        // [RULE5] skipped bits preshifted out, first step at load
        {divRem, divQuo} <= divStep('0, magA << DIV_SKIP[divClass], magB);
        divDen     <= magB;
        divIterTop <= DIV_ITER_FULL - DIV_SKIP[divClass];
        divNegQ    <= stSigned && (stA[WORD_W-1] ^ stB[WORD_W-1]);
        divNegR    <= stSigned && stA[WORD_W-1];
      end else if (divCnt >= 6'h02 && divCnt <= divIterTop) begin
        // [RULE4] one quotient bit per clock
        {divRem, divQuo} <= divStep(divRem, divQuo, divDen);
      end
    end
  end

  assign divHiFix = divNegR ? WORD_W'(-divRem) : divRem;
  assign divLoFix = divNegQ ? WORD_W'(-divQuo) : divQuo;

  // ==========================================================================
  // stage results
  logic [WORD_W-1:0]   hiCur;
  logic [WORD_W-1:0]   loCur;
  logic [2*WORD_W-1:0] mulResult;
  logic                stageDone;
  logic                stageWritesHiLo;
  logic                stageWritesGpr;
  logic [WORD_W-1:0]   gprData;

  // a divide finishing this edge is forwarded to the stage
  assign hiCur = divFinishing ? divHiFix : resultHigh;
  assign loCur = divFinishing ? divLoFix : resultLow;

  assign stageDone       = (seq == SEQ_FIRST && !stWide) || secondPass;
  assign stageWritesHiLo = stageDone && isMulFamily(stOp) && stOp != OP_MULTIPLY_TO_REGISTER;
  assign stageWritesGpr  = stageDone && stOp inside {OP_MULTIPLY_TO_REGISTER,
                           OP_MOVE_FROM_RESULT_HIGH, OP_MOVE_FROM_RESULT_LOW};

  // [RULE12] accumulate or subtract against current high/low
  always_comb begin
    unique case (stOp)
      OP_MULTIPLY_ACCUMULATE, OP_UNSIGNED_MULTIPLY_ACCUMULATE:
        mulResult = {hiCur, loCur} + product;
      OP_MULTIPLY_SUBTRACT, OP_UNSIGNED_MULTIPLY_SUBTRACT:
        mulResult = {hiCur, loCur} - product;
      default:
        mulResult = product;
    endcase
  end

  // [RULE10] move instructions copy high or low out
  always_comb begin
    unique case (stOp)
      OP_MOVE_FROM_RESULT_HIGH: gprData = hiCur;
      OP_MOVE_FROM_RESULT_LOW:  gprData = loCur;
      // [RULE11] low product word straight to the register
      default:                  gprData = product[WORD_W-1:0];
    endcase
  end

  // ==========================================================================
  // high/low result pair
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      resultHigh <= RESULT_RESET;
      resultLow  <= RESULT_RESET;
    end else if (clkEn) begin
      if (stageWritesHiLo) begin
        // [RULE7] written at the edge that ends the last operand pass
        // [RULE14] upper word high, lower word low
        {resultHigh, resultLow} <= mulResult;
      end else if (divFinishing) begin
        // [RULE14] remainder high, quotient low
        resultHigh <= divHiFix;
        resultLow  <= divLoFix;
      end
    end
  end

  // ==========================================================================
  // register writeback, one clock behind the stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gprWr <= '0;
    end else if (clkEn) begin
      // [RULE8] extra clock for the register write
      gprWr.valid     <= stageWritesGpr;
      gprWr.shadowSet <= stSet;
      gprWr.idx       <= stDest;
      gprWr.data      <= gprData;
    end
  end

  // ==========================================================================
  // issue interlock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stall <= 1'b0;
    end else if (clkEn) begin
      // [RULE3] wide multiply blocks the following clock
      // [RULE6] divide holds issue until one clock before its result
      stall <= (accept && (issueWide || isDivide(issue.op)))
             || next_divCnt >= DIV_CNT_STALL;
    end
  end

endmodule // mdvu_core

// ==== dv/mdvu_core_checker.sv ====
`timescale 1ns/10ps
module mdvu_core_checker (
  input wire logic                        core_clk,
  input wire logic                        rst_n,
  input wire logic                        clkEn,
  input wire mdvu_pkg::mdvu_issue_t       issue,
  input wire mdvu_pkg::mdvu_gpr_wr_t      extWr,
  input wire logic                        stall,
  input wire logic [mdvu_pkg::WORD_W-1:0] resultHigh,
  input wire logic [mdvu_pkg::WORD_W-1:0] resultLow,
  input wire mdvu_pkg::mdvu_gpr_wr_t      gprWr
);
  import mdvu_pkg::*;
  logic       taken, takeMul, takeDiv, takeRm, takeMov, takeWr;
  logic [5:0] runLen;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========
  // request decode and stall run length
  assign taken   = clkEn && issue.valid && issue.op != OP_NONE && !stall;
  assign takeMul = taken && issue.op inside {[OP_SIGNED_MULTIPLY:OP_MULTIPLY_TO_REGISTER]};
  assign takeDiv = taken && issue.op inside {OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE};
  assign takeRm  = taken && issue.op == OP_MULTIPLY_TO_REGISTER;
  assign takeMov = taken && issue.op inside {OP_MOVE_FROM_RESULT_HIGH, OP_MOVE_FROM_RESULT_LOW};
  assign takeWr  = takeRm || takeMov;

  always_ff @(posedge core_clk) begin
    if (!rst_n) runLen <= 6'h00;
    else if (clkEn) runLen <= stall ? runLen + 6'h01 : 6'h00;
  end

  // ==========
  // properties
  property p_reset;
    $rose(rst_n) |-> !stall && resultHigh == '0 && resultLow == '0 && !gprWr.valid;
  endproperty
  property p_runLen;
    $fell(stall) |-> runLen inside {6'h01, 6'h0A, 6'h11, 6'h18, 6'h1F};
  endproperty
  property p_stallCause;
    $rose(stall) |-> $past(taken);
  endproperty
  property p_wideOne;
    takeMul ##1 stall |=> !stall;
  endproperty
  property p_divStall;
    takeDiv |=> stall [*8];
  endproperty
  property p_rmNarrow;
    takeRm ##1 !stall |=> gprWr.valid && gprWr.idx == $past(issue.destIdx, 2)
      && gprWr.shadowSet == $past(issue.shadowSet, 2);
  endproperty
  property p_rmWide;
    takeRm ##1 stall |=> !gprWr.valid ##1 gprWr.valid && gprWr.idx == $past(issue.destIdx, 3);
  endproperty
  property p_move;
    takeMov |-> ##2 gprWr.valid && gprWr.data ==
      ($past(issue.op, 2) == OP_MOVE_FROM_RESULT_HIGH ? resultHigh : resultLow);
  endproperty
  property p_gprCause;
    gprWr.valid |-> $past(takeWr, 2) || $past(takeWr, 3);
  endproperty
  property p_frozen;
    !clkEn |=> $stable(resultHigh) && $stable(resultLow) && $stable(stall);
  endproperty

  a_reset: assert property (p_reset) else $error("results not cleared by reset");
  a_runLen: assert property (p_runLen) else $error("stall run length wrong");
  a_stallCause: assert property (p_stallCause) else $error("stall without request");
  a_wideOne: assert property (p_wideOne) else $error("wide stall too long");
  a_divStall: assert property (p_divStall) else $error("divide did not stall");
  a_rmNarrow: assert property (p_rmNarrow) else $error("register write late");
  a_rmWide: assert property (p_rmWide) else $error("wide register write timing");
  a_move: assert property (p_move) else $error("move data wrong");
  a_gprCause: assert property (p_gprCause) else $error("stray register write");
  a_frozen: assert property (p_frozen) else $error("state moved while frozen");

  c_div: cover property (takeDiv);
  c_wide: cover property (takeMul ##1 stall);
  c_move: cover property (takeMov ##2 gprWr.valid);
endmodule // mdvu_core_checker

bind mdvu_core mdvu_core_checker u_mdvu_core_checker (
  .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .issue(issue),
  .extWr(extWr), .stall(stall), .resultHigh(resultHigh),
  .resultLow(resultLow), .gprWr(gprWr)
);

// ==== dv/mdvu_pipe_model.sv ====
`timescale 1ns/10ps
module mdvu_pipe_model (
  input  wire logic                   core_clk,
  input  wire logic                   stall,
  input  wire mdvu_pkg::mdvu_gpr_wr_t gprWr,
  output mdvu_pkg::mdvu_issue_t       issue,
  output mdvu_pkg::mdvu_gpr_wr_t      extWr
);
  import mdvu_pkg::*;

  initial begin
    issue = '0;
    extWr = '0;
  end

  // ==========
  // request, register write and release
  // hold while stalled
  task automatic send(input mdvu_issue_t r);
    issue <= r;
    do @(negedge core_clk); while (stall !== 1'h0);
    @(posedge core_clk);
  endtask

  task automatic wr(input logic s, input logic [4:0] i, input logic [31:0] d);
    extWr <= '{1'h1, s, i, d};
    @(posedge core_clk);
  endtask

  // released fields flip so stale values are never trusted
  task automatic idle(input int n);
    issue <= {1'h0, ~issue[$bits(issue)-2:0]};
    extWr <= {1'h0, ~extWr[$bits(extWr)-2:0]};
    repeat (n) @(posedge core_clk);
  endtask
endmodule // mdvu_pipe_model

// ==== dv/mdvu_core_tb.sv ====
`timescale 1ns/10ps
module mdvu_core_tb;
  import mdvu_pkg::*;
  logic              core_clk, rst_n, clkEn, stall, s;
  mdvu_issue_t       issue;
  mdvu_gpr_wr_t      extWr, gprWr;
  logic [WORD_W-1:0] resultHigh, resultLow, ra, rb;
  logic [63:0]       acc, hVal[$];
  logic [37:0]       gVal[$];
  longint            cyc, t1, t2, t3, hDue[$], gDue[$];
  int                numErrors, comparisons, w;

  mdvu_core u_mdvu_core (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .issue(issue), .extWr(extWr), .stall(stall), .resultHigh(resultHigh),
    .resultLow(resultLow), .gprWr(gprWr));
  mdvu_pipe_model u_mdvu_pipe_model (.core_clk(core_clk), .stall(stall),
    .gprWr(gprWr), .issue(issue), .extWr(extWr));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  // ==========
  // comparison and verdict
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finalReport();
    if (numErrors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(negedge core_clk) begin
    if (hDue.size() > 0 && hDue[0] == cyc) begin
      chk({resultHigh, resultLow}, hVal[0]);
      void'(hDue.pop_front());
      void'(hVal.pop_front());
    end
    if (gDue.size() > 0 && gDue[0] == cyc) begin
      chk({gprWr.valid, gprWr.shadowSet, gprWr.idx, gprWr.data}, {1'h1, gVal[0]});
      void'(gDue.pop_front());
      void'(gVal.pop_front());
    end else chk(gprWr.valid, 1'h0);
  end

  // ==========
  // stimulus helpers
  task automatic rst(input int n);
    rst_n <= 1'h0;
    repeat (n) @(posedge core_clk);
    rst_n <= 1'h1;
    acc = '0;
    @(negedge core_clk);
    chk({resultHigh, resultLow}, '0);
    chk({stall, gprWr.valid}, '0);
    @(posedge core_clk);
  endtask

  task automatic load(input logic st);
    u_mdvu_pipe_model.wr(st, 5'h01, ra);
    u_mdvu_pipe_model.wr(st, 5'h02, rb);
    u_mdvu_pipe_model.wr(!st, 5'h01, ~ra);
    u_mdvu_pipe_model.wr(!st, 5'h02, ~rb);
  endtask

  task automatic go(input mdvu_op_t op, input logic st, output longint t);
    longint      sp;
    logic [63:0] up;
    logic        sg;
    int          lat;
    sp = longint'($signed(ra)) * longint'($signed(rb));
    up = {32'h0, ra} * {32'h0, rb};
    sg = op inside {OP_SIGNED_MULTIPLY, OP_MULTIPLY_ACCUMULATE, OP_MULTIPLY_SUBTRACT,
                    OP_MULTIPLY_TO_REGISTER, OP_SIGNED_DIVIDE};
    lat = (sg ? (rb[31:15] == '0 || rb[31:15] == '1) : rb[31:16] == '0) ? 1 : 2;
    u_mdvu_pipe_model.send('{1'h1, op, st, 5'h01, 5'h02, 5'h03});
    t = cyc + 1;
    case (op)
      OP_SIGNED_MULTIPLY: acc = sp;
      OP_UNSIGNED_MULTIPLY: acc = up;
      OP_MULTIPLY_ACCUMULATE: acc += sp;
      OP_UNSIGNED_MULTIPLY_ACCUMULATE: acc += up;
      OP_MULTIPLY_SUBTRACT: acc -= sp;
      OP_UNSIGNED_MULTIPLY_SUBTRACT: acc -= up;
      OP_SIGNED_DIVIDE: acc = {$signed(ra) % $signed(rb), $signed(ra) / $signed(rb)};
      OP_UNSIGNED_DIVIDE: acc = {ra % rb, ra / rb};
      default: ;
    endcase
    if (op inside {OP_SIGNED_DIVIDE, OP_UNSIGNED_DIVIDE}) begin
      lat = 33;
      for (int k = 24; k >= 8; k -= 8)
        if (sg ? ($signed(ra << (32 - k)) >>> (32 - k)) == $signed(ra) : (ra >> k) == 0)
          lat = 12 + 7 * (k / 8 - 1);
    end
    if (op == OP_MULTIPLY_TO_REGISTER) begin
      gDue.push_back(t + lat);
      gVal.push_back({st, 5'h03, sp[31:0]});
    end else if (op inside {OP_MOVE_FROM_RESULT_HIGH, OP_MOVE_FROM_RESULT_LOW}) begin
      gDue.push_back(t + 1);
      gVal.push_back({st, 5'h03, op == OP_MOVE_FROM_RESULT_HIGH ? acc[63:32] : acc[31:0]});
    end else begin
      hDue.push_back(t + lat);
      hVal.push_back(acc);
    end
  endtask

  // ==========
  // scenarios
  initial begin
    clkEn = 1'h1;
    cyc = 0;
    void'($urandom(32'h7826125B));
    rst(20);
    for (int o = 1; o <= 7; o++)
      for (int n = 0; n < 2; n++) begin
        s = 1'($urandom);
        ra = $urandom;
        rb = $urandom;
        if (n == 0) rb = (o % 2 == 1) ? {{16{rb[15]}}, rb[15:0]} : {16'h0, rb[15:0]};
        else rb[31:30] = 2'h1;
        load(s);
        go(mdvu_op_t'(o), s, t1);
        go(mdvu_op_t'(o), s, t2);
        u_mdvu_pipe_model.idle(3);
        chk(t2 - t1, n + 1);
      end
    clkEn <= 1'h0;
    u_mdvu_pipe_model.idle(3);
    clkEn <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      s = 1'($urandom);
      w = 8 * (k % 4 + 1);
      ra = ($urandom & ((32'h1 << (w - 1)) - 1)) | (32'h1 << (w - 2));
      if (k < 4 && $urandom % 2) ra = -ra;
      rb = $urandom % 32'h1FF + 1;
      if (k == 2) rb = -rb;
      load(s);
      go(k < 4 ? OP_SIGNED_DIVIDE : OP_UNSIGNED_DIVIDE, s, t1);
      go(OP_MOVE_FROM_RESULT_LOW, s, t2);
      go(OP_MOVE_FROM_RESULT_HIGH, s, t3);
      u_mdvu_pipe_model.idle(3);
      chk(t2 - t1, 11 + 7 * (k % 4));
      chk(t3 - t2, 1);
    end
    rst(1);
    go(OP_MOVE_FROM_RESULT_HIGH, 1'h0, t1);
    u_mdvu_pipe_model.idle(40);
    chk(hDue.size() + gDue.size(), 0);
    finalReport();
  end

  initial begin
    #200000;
    numErrors++;
    finalReport();
  end
endmodule // mdvu_core_tb
